// >>> hw/host_port_pkg.sv
// Overview of operation
// RULE1: Wake pin low 50us restarts device.
// RULE2: Ready falls when restart is complete.
// RULE3: Ready falls when measurement result ready.
// RULE4: Standby releases every signal pin.
// RULE5: Straps 11/10/01/00 select 115200/38400/19200/9600.
// RULE6: Straps sampled only at restart.
// RULE7: Shared pin low selects SPI, else UART.
// RULE8: Detection lasts about 25ms until ready.
// RULE9: Host holds shared pin steady during detection.
// RULE10: SPI host mode 0, UART idles high.
// RULE11: Host forces mode by strapping, then wakes.
// RULE12: One pin set serves both interfaces.
// RULE13: Built-in power-on reset starts detection.
// RULE14: Host uses standby only with wake wired.
// RULE15: Standby entered after reply read or sent.
// RULE16: Ready idles high, returns high between events.
package host_port_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int WAKE_MIN_US = 50;
   localparam int WAKE_MIN_CYCLES = (WAKE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DETECT_MS = 25;
   localparam int DETECT_CYCLES = (DETECT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int READY_LOW_US = 10;
   localparam int READY_LOW_CYCLES = (READY_LOW_US * 1000) / CLK_PERIOD_NS;
   localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

   // ****************************************************************
   // Baud strap decode
   // ****************************************************************
   localparam int BAUD_11 = 115200;
   localparam int BAUD_10 = 38400;
   localparam int BAUD_01 = 19200;
   localparam int BAUD_00 = 9600;
   localparam logic [1:0] STRAP_RESET = 2'h3;
   localparam logic [15:0] BIT_CYCLES_11 = 16'((CLK_HZ + BAUD_11 / 2) / BAUD_11);
   localparam logic [15:0] BIT_CYCLES_10 = 16'((CLK_HZ + BAUD_10 / 2) / BAUD_10);
   localparam logic [15:0] BIT_CYCLES_01 = 16'((CLK_HZ + BAUD_01 / 2) / BAUD_01);
   localparam logic [15:0] BIT_CYCLES_00 = 16'((CLK_HZ + BAUD_00 / 2) / BAUD_00);

   typedef enum logic [1:0] {
      BAUD_9600,
      BAUD_19200,
      BAUD_38400,
      BAUD_115200
   } baudSel_t;

   // Shared pins as seen on their input side.
   typedef struct packed {
      logic sckRx;
      logic misoStrapHi;
      logic mosiStrapLo;
      logic nssTx;
      logic wakeN;
   } pinIn_t;

   // Output and enable pairs for the driven pins.
   typedef struct packed {
      logic misoOut;
      logic misoOe;
      logic txOut;
      logic txOe;
      logic readyOut;
      logic readyOe;
   } pinOut_t;

   localparam int PIN_IN_W = $bits(pinIn_t);

endpackage

// >>> hw/sync_stage.sv
module sync_stage #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= INIT;
         syncOut <= INIT;
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule

// >>> hw/host_port_ctrl.sv
module host_port_ctrl
   import host_port_pkg::*;
#(
   parameter int DETECT_LEN = DETECT_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire pinIn_t pinIn,
   output pinOut_t pinOut,
   input wire logic measDone,
   input wire logic standbyCmd,
   input wire logic spiReplyRead,
   input wire logic uartReplySent,
   input wire logic spiMisoData,
   input wire logic uartTxData,
   output logic spiMode,
   output baudSel_t baudSel,
   output logic [15:0] bitCycles,
   output logic linkReady,
   output logic inStandby,
   output logic restartPulse,
   output pinIn_t pinSync
);

   typedef enum logic [1:0] {
      ST_RESTART,
      ST_DETECT,
      ST_ACTIVE,
      ST_STANDBY
   } state_t;

   localparam int WAKE_W = $clog2(WAKE_MIN_CYCLES + 1);
   localparam int DET_W = $clog2(DETECT_LEN + 1);
   localparam int RDY_W = $clog2(READY_LOW_CYCLES + 1);

   state_t state_q;
   pinIn_t pinS;
   logic [WAKE_W-1:0] wakeCnt_q;
   logic wakeHit;
   logic [DET_W-1:0] detCnt_q;
   logic detDone;
   logic standbyArm_q;
   logic readyPend_q;
   logic [RDY_W-1:0] readyCnt_q;
   logic readyLow_q;
   logic active;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Every pin the host drives is asynchronous to clk, including the wake line.
   sync_stage #(
      .WIDTH(PIN_IN_W),
      .INIT({PIN_IN_W{1'b1}})
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .asyncIn(pinIn),
      .syncOut(pinS)
   );

   assign active = (state_q == ST_ACTIVE);
   assign wakeHit = !pinS.wakeN && (wakeCnt_q == WAKE_W'(WAKE_MIN_CYCLES - 1));
   assign detDone = (detCnt_q == DET_W'(DETECT_LEN - 1));

   // ****************************************************************
   // Wake/reset pulse qualification
   // ****************************************************************
   // Shorter low pulses are glitches and leave the device alone.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wakeCnt_q <= '0;
      end else if (pinS.wakeN) begin
         wakeCnt_q <= '0;
      end else if (wakeCnt_q != WAKE_W'(WAKE_MIN_CYCLES)) begin
         wakeCnt_q <= wakeCnt_q + WAKE_W'(1); // RULE1
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   // Release of resetn acts as the internal power-on reset and goes straight into detection.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_DETECT; // RULE13
      end else begin
         case (state_q)
            ST_RESTART: begin
               if (pinS.wakeN) begin
                  state_q <= ST_DETECT;
               end
            end
            ST_DETECT: begin
               if (wakeHit) begin
                  state_q <= ST_RESTART;
               end else if (detDone) begin
                  state_q <= ST_ACTIVE; // RULE8
               end
            end
            ST_ACTIVE: begin
               if (wakeHit) begin
                  state_q <= ST_RESTART;
               end else if (standbyArm_q && (spiMode ? spiReplyRead : uartReplySent)) begin
                  state_q <= ST_STANDBY; // RULE15
               end
            end
            ST_STANDBY: begin
               // Only a qualified wake pulse brings the device back.
               if (wakeHit) begin
                  state_q <= ST_RESTART; // RULE1
               end
            end
            default: begin
               state_q <= ST_RESTART;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         detCnt_q <= '0;
      end else if (state_q != ST_DETECT || detDone) begin
         detCnt_q <= '0;
      end else begin
         detCnt_q <= detCnt_q + DET_W'(1); // RULE8
      end
   end

   // A standby request waits for its reply to complete; arrival beats clear.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         standbyArm_q <= 1'b0;
      end else if (active && standbyCmd) begin
         standbyArm_q <= 1'b1;
      end else if (!active) begin
         standbyArm_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Mode and baud capture
   // ****************************************************************
   // Captured at the end of the window, when the host has held the pins steady.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         spiMode <= 1'b0;
         baudSel <= BAUD_115200;
         bitCycles <= BIT_CYCLES_11;
      end else if (state_q == ST_DETECT && detDone && !wakeHit) begin
         spiMode <= !pinS.sckRx; // RULE7
         case ({pinS.misoStrapHi, pinS.mosiStrapLo}) // RULE6
            2'h3: begin
               baudSel <= BAUD_115200; // RULE5
               bitCycles <= BIT_CYCLES_11;
            end
            2'h2: begin
               baudSel <= BAUD_38400;
               bitCycles <= BIT_CYCLES_10;
            end
            2'h1: begin
               baudSel <= BAUD_19200;
               bitCycles <= BIT_CYCLES_01;
            end
            default: begin
               baudSel <= BAUD_9600;
               bitCycles <= BIT_CYCLES_00;
            end
         endcase
      end
   end

   // ****************************************************************
   // Ready indication
   // ****************************************************************
   // An event during a low pulse is held and issued after ready returns high,
   // so the host sees a separate falling edge for it; further events in the same low pulse share that edge.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readyPend_q <= 1'b0;
      end else if ((state_q == ST_DETECT && detDone && !wakeHit) || (active && measDone)) begin
         readyPend_q <= 1'b1; // RULE2 RULE3
      end else if (!readyLow_q && readyPend_q) begin
         readyPend_q <= 1'b0;
      end else if (state_q == ST_RESTART || state_q == ST_STANDBY) begin
         readyPend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readyLow_q <= 1'b0;
         readyCnt_q <= '0;
      end else if (state_q == ST_RESTART || state_q == ST_STANDBY) begin
         readyLow_q <= 1'b0;
         readyCnt_q <= '0;
      end else if (readyLow_q) begin
         if (readyCnt_q == RDY_W'(READY_LOW_CYCLES - 1)) begin
            readyLow_q <= 1'b0; // RULE16
            readyCnt_q <= '0;
         end else begin
            readyCnt_q <= readyCnt_q + RDY_W'(1);
         end
      end else if (readyPend_q) begin
         readyLow_q <= 1'b1; // RULE2 RULE3
      end
   end

   // ****************************************************************
   // Pin drivers and status
   // ****************************************************************
   // MISO and strap-high share one pin, select and TX share another.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinOut <= '{misoOut: 1'b0, misoOe: 1'b0, txOut: 1'b1, txOe: 1'b0,
                     readyOut: 1'b1, readyOe: 1'b1};
      end else begin
         pinOut.misoOut <= spiMisoData; // RULE12
         pinOut.misoOe <= active && spiMode && !pinS.nssTx; // RULE12
         pinOut.txOut <= uartTxData;
         pinOut.txOe <= active && !spiMode; // RULE12
         pinOut.readyOut <= !readyLow_q; // RULE16
         pinOut.readyOe <= (state_q != ST_STANDBY); // RULE4
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         linkReady <= 1'b0;
         inStandby <= 1'b0;
         restartPulse <= 1'b0;
         pinSync <= '1;
      end else begin
         linkReady <= active;
         inStandby <= (state_q == ST_STANDBY);
         restartPulse <= wakeHit && (state_q != ST_RESTART);
         pinSync <= pinS;
      end
   end

endmodule

// >>> tb/host_port_ctrl_props.sv
module host_port_ctrl_props
   import host_port_pkg::*;
#(
   parameter int DETECT_LEN = DETECT_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire pinIn_t pinSync,
   input wire pinOut_t pinOut,
   input wire logic measDone,
   input wire logic spiMode,
   input wire baudSel_t baudSel,
   input wire logic [15:0] bitCycles,
   input wire logic linkReady,
   input wire logic inStandby,
   input wire logic restartPulse
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // ********
   // Detection length
   // ********
   // Counts detection cycles and stops one past the window; a low wake pin pauses it,
   // so time spent in restart is not counted. The extra count is the cycle in which
   // linkReady itself is registered.
   int detectCnt_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         detectCnt_q <= 0;
      end else if (restartPulse) begin
         detectCnt_q <= 0;
      end else if (!linkReady && pinSync.wakeN && detectCnt_q <= DETECT_LEN) begin
         detectCnt_q <= detectCnt_q + 1;
      end
   end
   a_detect_len: assert property ($rose(linkReady) |-> detectCnt_q == DETECT_LEN + 1)
      else $error("detection too short");
   a_standby_pins: assert property (inStandby && $past(inStandby) |->
      !pinOut.misoOe && !pinOut.txOe && !pinOut.readyOe) else $error("pin driven in standby");
   a_ready_width: assert property ($fell(pinOut.readyOut) |-> !pinOut.readyOut [*8])
      else $error("ready pulse too short");
   a_detect_ready: assert property ($rose(linkReady) |-> ##[1:3] $fell(pinOut.readyOut))
      else $error("no ready after detection");
   a_meas_ready: assert property (measDone && linkReady && pinOut.readyOut |->
      ##[1:3] $fell(pinOut.readyOut)) else $error("no ready after measurement");
   a_mode_hold: assert property (linkReady && $past(linkReady) |->
      $stable(spiMode) && $stable(baudSel) && $stable(bitCycles))
      else $error("mode changed while active");
   a_wake_restart: assert property (restartPulse |-> !pinSync.wakeN ##1 !linkReady)
      else $error("restart without wake");
   a_pin_share: assert property (linkReady && $past(linkReady) |->
      pinOut.txOe == !spiMode && (spiMode || !pinOut.misoOe)) else $error("wrong pin owner");
   c_ready: cover property ($fell(pinOut.readyOut));
   c_standby: cover property (inStandby);
   c_restart: cover property (restartPulse);
endmodule

bind host_port_ctrl host_port_ctrl_props #(.DETECT_LEN(DETECT_LEN)) props_u (
   .clk(clk), .resetn(resetn), .pinSync(pinSync), .pinOut(pinOut), .measDone(measDone),
   .spiMode(spiMode), .baudSel(baudSel), .bitCycles(bitCycles), .linkReady(linkReady),
   .inStandby(inStandby), .restartPulse(restartPulse));

// >>> tb/host_model.sv
module host_model
   import host_port_pkg::*;
(
   input wire logic clk,
   input wire pinOut_t pinOut,
   output pinIn_t pinIn
);
   timeunit 1ns;
   timeprecision 100ps;
   // ********
   // Host side of the shared pins
   // ********
   // Straps and wake have pull-ups, so an idle host leaves them high.
   logic sck = 1'b1;
   logic hi = 1'b1;
   logic lo = 1'b1;
   logic nss = 1'b1;
   logic wk = 1'b1;
   assign pinIn = '{sckRx: sck, misoStrapHi: pinOut.misoOe ? pinOut.misoOut : hi,
      mosiStrapLo: lo, nssTx: pinOut.txOe ? pinOut.txOut : nss, wakeN: wk};
   task automatic set_link(input logic spi, input logic [1:0] strap);
      sck = !spi;
      {hi, lo} = strap;
   endtask
   task automatic wake(input int len);
      @(posedge clk);
      wk <= 1'b0;
      repeat (len) @(posedge clk);
      wk <= 1'b1;
   endtask
   // The link clock runs only inside a frame and rests low, as in mode 0.
   task automatic frame();
      nss = 1'b0;
      #37;
      repeat (16) #100 sck = ~sck;
      #37;
      nss = 1'b1;
   endtask
endmodule

// >>> tb/host_port_ctrl_tb.sv
module host_port_ctrl_tb
   import host_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DL = 200;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic measDone = 1'b0;
   logic standbyCmd = 1'b0;
   logic spiReplyRead = 1'b0;
   logic uartReplySent = 1'b0;
   logic misoData = 1'b0;
   logic txData = 1'b1;
   pinIn_t pinIn;
   pinOut_t pinOut;
   logic spiMode, linkReady, inStandby;
   baudSel_t baudSel;
   logic [15:0] bitCycles;
   int n_mismatch = 0;
   int samples_checked = 0;
   int waited;
   baudSel_t expSel[4] = '{BAUD_9600, BAUD_19200, BAUD_38400, BAUD_115200};
   logic [15:0] expBit[4] = '{BIT_CYCLES_00, BIT_CYCLES_01, BIT_CYCLES_10, BIT_CYCLES_11};
   host_model host_u (.clk(clk), .pinOut(pinOut), .pinIn(pinIn));
   host_port_ctrl #(.DETECT_LEN(DL)) dut_u (
      .clk(clk), .resetn(resetn), .pinIn(pinIn), .pinOut(pinOut), .measDone(measDone),
      .standbyCmd(standbyCmd), .spiReplyRead(spiReplyRead), .uartReplySent(uartReplySent),
      .spiMisoData(misoData), .uartTxData(txData), .spiMode(spiMode), .baudSel(baudSel),
      .bitCycles(bitCycles), .linkReady(linkReady), .inStandby(inStandby),
      .restartPulse(), .pinSync());
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ********
   // Access tasks
   // ********
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Sampling on the falling edge keeps clear of the design's own updates.
   task automatic wait_ready(input logic lvl, input int lim);
      for (waited = 0; pinOut.readyOut !== lvl; waited++) begin
         if (waited == lim) begin
            n_mismatch++;
            give_verdict();
         end
         @(negedge clk);
      end
   endtask
   task automatic ev(input int k);
      @(posedge clk);
      measDone <= (k == 0);
      standbyCmd <= (k == 1);
      spiReplyRead <= (k == 2);
      uartReplySent <= (k == 3);
      @(posedge clk);
      {measDone, standbyCmd, spiReplyRead, uartReplySent} <= 4'h0;
   endtask
   task automatic restart(input logic spi, input logic [1:0] strap);
      host_u.set_link(spi, strap);
      host_u.wake(2100);
      check(16'(linkReady), 16'h0);
      wait_ready(1'b0, DL + 40);
      check(16'(waited >= DL), 16'h1);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      wait_ready(1'b0, DL + 40);
      check(16'(waited >= DL), 16'h1);
      check(16'(spiMode), 16'h0);
      check(16'(baudSel), 16'(BAUD_115200));
      for (int c = 0; c < 4; c++) begin
         restart(1'b0, 2'(c));
         check(16'(baudSel), 16'(expSel[c]));
         check(bitCycles, expBit[c]);
         check(16'(pinOut.txOe), 16'h1);
         @(posedge clk);
         txData <= !txData;
         repeat (2) @(negedge clk);
         check(16'(pinOut.txOut), 16'(txData));
      end
      host_u.set_link(1'b0, 2'h0);
      host_u.wake(1000);
      repeat (50) @(negedge clk);
      check(16'(baudSel), 16'(BAUD_115200));
      check(16'(linkReady), 16'h1);
      ev(1);
      ev(2);
      repeat (3) @(negedge clk);
      check(16'(inStandby), 16'h0);
      ev(3);
      repeat (3) @(negedge clk);
      check(16'(inStandby), 16'h1);
      restart(1'b1, 2'h3);
      check(16'(spiMode), 16'h1);
      fork
         host_u.frame();
         begin
            @(posedge clk);
            misoData <= 1'b1;
            repeat (20) @(negedge clk);
            check(16'(pinOut.misoOe), 16'h1);
            check(16'(pinOut.misoOut), 16'(misoData));
         end
      join
      wait_ready(1'b1, 500);
      ev(0);
      wait_ready(1'b0, 10);
      check(16'(waited <= 4), 16'h1);
      ev(0);
      wait_ready(1'b1, 500);
      check(16'(waited > 300), 16'h1);
      wait_ready(1'b0, 10);
      check(16'(waited <= 4), 16'h1);
      wait_ready(1'b1, 500);
      ev(1);
      ev(2);
      repeat (3) @(negedge clk);
      check(16'(inStandby), 16'h1);
      check(16'({pinOut.misoOe, pinOut.txOe, pinOut.readyOe}), 16'h0);
      restart(1'b1, 2'h3);
      check(16'(inStandby), 16'h0);
      give_verdict();
   end
endmodule
